// ### design/ifd_pkg.sv
package ifd_pkg;

  // Terminal count, code width and the position of the pulse-capable input.
  localparam int unsigned N_TERM    = 5;
  localparam int unsigned CODE_W    = 6;
  localparam int unsigned HS_TERM   = 4;
  localparam int unsigned N_FUNC    = 16;
  localparam int unsigned CNT_W     = 32;

  // Function codes handled by this decoder.
  localparam logic [5:0] F_PLC_PAUSE     = 6'h12;
  localparam logic [5:0] F_PLC_STOP_RST  = 6'h13;
  localparam logic [5:0] F_PID_PAUSE     = 6'h14;
  localparam logic [5:0] F_PID_SWITCH    = 6'h15;
  localparam logic [5:0] F_CNT_TRIG      = 6'h16;
  localparam logic [5:0] F_CNT_CLR       = 6'h17;
  localparam logic [5:0] F_LEN_CLR       = 6'h18;
  localparam logic [5:0] F_ACC_HOLD      = 6'h19;
  localparam logic [5:0] F_DC_BRAKE      = 6'h1a;
  localparam logic [5:0] F_UPDN_CLR      = 6'h1b;
  localparam logic [5:0] F_CMD_KEYPAD    = 6'h1c;
  localparam logic [5:0] F_CMD_TERMINAL  = 6'h1d;
  localparam logic [5:0] F_CMD_COMM      = 6'h1e;
  localparam logic [5:0] F_FREQ_MAIN     = 6'h1f;
  localparam logic [5:0] F_FREQ_AUX      = 6'h20;
  localparam logic [5:0] F_HS_CLR        = 6'h21;

  // Bit index of each function inside the decoded vector.
  localparam int unsigned B_PLC_PAUSE    = 0;
  localparam int unsigned B_PLC_STOP_RST = 1;
  localparam int unsigned B_PID_PAUSE    = 2;
  localparam int unsigned B_PID_SWITCH   = 3;
  localparam int unsigned B_CNT_TRIG     = 4;
  localparam int unsigned B_CNT_CLR      = 5;
  localparam int unsigned B_LEN_CLR      = 6;
  localparam int unsigned B_ACC_HOLD     = 7;
  localparam int unsigned B_DC_BRAKE     = 8;
  localparam int unsigned B_UPDN_CLR     = 9;
  localparam int unsigned B_CMD_KEYPAD   = 10;
  localparam int unsigned B_CMD_TERMINAL = 11;
  localparam int unsigned B_CMD_COMM     = 12;
  localparam int unsigned B_FREQ_MAIN    = 13;
  localparam int unsigned B_FREQ_AUX     = 14;
  localparam int unsigned B_HS_CLR       = 15;

  // Settings that enable terminal-driven behaviour.
  localparam logic       HS_MODE_PULSE   = 1'b1;
  localparam logic       PID_COND_TERM   = 1'b1;

  // Reset values.
  localparam logic [31:0] CNT_RESET      = 32'h0000_0000;

  // Command source and frequency source selections.
  typedef enum logic [1:0] {
    IFD_CMD_NONE,
    IFD_CMD_KEYPAD,
    IFD_CMD_TERMINAL,
    IFD_CMD_COMM
  } ifd_cmd_e;

  typedef enum logic [1:0] {
    IFD_FREQ_NONE,
    IFD_FREQ_MAIN,
    IFD_FREQ_AUX
  } ifd_freq_e;

endpackage

// ### design/ifd_func_if.sv
`timescale 1ns/100ps
interface ifd_func_if;

  // Decoded function levels, their rising edges and the pulse input edge.
  logic [15:0] act;
  logic [15:0] rise;
  logic        hs_rise;

  modport src (output act, output rise, output hs_rise);
  modport dst (input act, input rise, input hs_rise);

endinterface

// ### design/ifd_term_decode.sv
`timescale 1ns/100ps
module ifd_term_decode (
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic [4:0]      term_closed,
  input  wire logic [4:0]      term_positive,
  input  wire logic            hs_pulse_mode,
  input  wire logic [4:0][5:0] term_func,
  ifd_func_if.src              fn
);

  typedef struct packed {
    logic [15:0] act;
    logic [15:0] act_d;
    logic        hs_lvl;
    logic        hs_lvl_d;
    logic        live;
    logic        primed;
  } ifd_dec_s;

  ifd_dec_s        st_reg;
  ifd_dec_s        st_next;
  logic [4:0]      term_act;
  logic [4:0][15:0] term_hit;

  // Per-terminal sense and one-hot decode of the assigned function.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_term
      assign term_act[gi] = term_closed[gi] ~^ term_positive[gi]; // R16
      always_comb
      begin
        term_hit[gi] = 16'h0000;
        if (term_act[gi] && !(gi == ifd_pkg::HS_TERM &&
            hs_pulse_mode == ifd_pkg::HS_MODE_PULSE)) // R15
        begin
          if (term_func[gi] >= ifd_pkg::F_PLC_PAUSE &&
              term_func[gi] <= ifd_pkg::F_HS_CLR)
          begin
            term_hit[gi][4'(term_func[gi] - ifd_pkg::F_PLC_PAUSE)] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // Merge terminals and keep the previous levels for edge detection.
  always_comb
  begin
    st_next          = st_reg;
    st_next.act      = 16'h0000;
    for (int i = 0; i < 5; i++)
    begin
      st_next.act = st_next.act | term_hit[i];
    end
    st_next.act_d    = st_reg.act;
    st_next.hs_lvl   = term_act[ifd_pkg::HS_TERM] &&
                       (hs_pulse_mode == ifd_pkg::HS_MODE_PULSE); // R15
    st_next.hs_lvl_d = st_reg.hs_lvl;
    // Edges are trusted only once the delayed copies hold real levels.
    st_next.live     = 1'b1;
    st_next.primed   = st_reg.live;
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Levels and registered edges toward the command stage; a terminal that
  // is already active when reset ends gives no false edge.
  assign fn.act     = st_reg.act;
  assign fn.rise    = st_reg.act & ~st_reg.act_d & {16{st_reg.primed}};
  assign fn.hs_rise = st_reg.hs_lvl & ~st_reg.hs_lvl_d & st_reg.primed;

endmodule

// ### design/ifd_input_terminal_decoder.sv
`timescale 1ns/100ps
// Contract
// R01: Function 18 active pauses program sequence at zero frequency.
// R02: Function 19 blocks sequence start, stops running sequence, resets step.
// R03: Function 20 suspends PID and holds present output frequency.
// R04: Function 21 selects second PID set when switching condition equals 1.
// R05: Function 22 is counter input; count value restorable after power loss.
// R06: Function 23 active clears the built-in counter.
// R07: Function 24 active clears the accumulated length.
// R08: Function 25 holds speed except stop; no effect while jogging.
// R09: Function 26 applies DC brake when decelerating in stop-brake mode.
// R10: Function 27 clears up/down offset when channel is terminal up/down.
// R11: Functions 28-30 pick command source; keypad over terminal over comms.
// R12: Keep run state on switch; two-wire terminal follows start setting.
// R13: Functions 31-32 pick frequency source; main wins over auxiliary.
// R14: Function 33 active clears the high-frequency pulse count.
// R15: Fifth terminal is switch input or, with setting 1, pulse input.
// R16: Each terminal has selectable positive or negative logic sense.
// R17: Counter advances per rising edge; held clear keeps it at zero.
module ifd_input_terminal_decoder (
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic [4:0]      term_closed,
  input  wire logic [4:0]      term_positive,
  input  wire logic            hs_pulse_mode,
  input  wire logic [4:0][5:0] term_func,
  input  wire logic            pid_switch_cond,
  input  wire logic            plc_running,
  input  wire logic            jog_active,
  input  wire logic            decelerating,
  input  wire logic            stop_dc_brake_mode,
  input  wire logic            freq_chan_updown,
  input  wire logic            two_wire_mode,
  input  wire logic            cnt_restore,
  input  wire logic [31:0]     cnt_restore_value,
  output logic                 plc_zero_freq,
  output logic                 plc_start_inhibit,
  output logic                 plc_decel_stop,
  output logic                 plc_step_reset,
  output logic                 pid_hold,
  output logic                 pid_set2,
  output logic [31:0]          cnt_value,
  output logic                 length_clear,
  output logic                 accel_hold,
  output logic                 dc_brake_now,
  output logic                 updown_clear,
  output logic [1:0]           cmd_src,
  output logic                 cmd_keep_run,
  output logic                 cmd_follow_start,
  output logic [1:0]           freq_src,
  output logic [31:0]          hs_count
);

  typedef struct packed {
    logic        plc_zero_freq;
    logic        plc_start_inhibit;
    logic        plc_decel_stop;
    logic        plc_step_reset;
    logic        pid_hold;
    logic        pid_set2;
    logic [31:0] cnt_value;
    logic        length_clear;
    logic        accel_hold;
    logic        dc_brake_now;
    logic        updown_clear;
    logic [1:0]  cmd_src;
    logic        cmd_keep_run;
    logic        cmd_follow_start;
    logic [1:0]  freq_src;
    logic [31:0] hs_count;
  } ifd_top_s;

  ifd_top_s   st_reg;
  ifd_top_s   st_next;
  ifd_func_if fn ();

  // Terminal sensing and function decode.
  ifd_term_decode u_dec (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .term_closed   (term_closed),
    .term_positive (term_positive),
    .hs_pulse_mode (hs_pulse_mode),
    .term_func     (term_func),
    .fn            (fn.src)
  );

  // Command stage: every output is registered; flags follow decoded levels, the two counts follow edges.
  always_comb
  begin
    st_next = st_reg;
    st_next.plc_zero_freq     = fn.act[ifd_pkg::B_PLC_PAUSE]; // R01
    st_next.plc_start_inhibit = fn.act[ifd_pkg::B_PLC_STOP_RST]; // R02
    st_next.plc_decel_stop    = fn.act[ifd_pkg::B_PLC_STOP_RST] &&
                                plc_running; // R02
    st_next.plc_step_reset    = fn.act[ifd_pkg::B_PLC_STOP_RST]; // R02
    st_next.pid_hold          = fn.act[ifd_pkg::B_PID_PAUSE]; // R03
    st_next.pid_set2          = fn.act[ifd_pkg::B_PID_SWITCH] &&
                                (pid_switch_cond ==
                                 ifd_pkg::PID_COND_TERM); // R04
    st_next.length_clear      = fn.act[ifd_pkg::B_LEN_CLR]; // R07
    // Stop commands bypass this hold; the motion core honours them.
    st_next.accel_hold        = fn.act[ifd_pkg::B_ACC_HOLD] &&
                                !jog_active; // R08
    st_next.dc_brake_now      = fn.act[ifd_pkg::B_DC_BRAKE] &&
                                decelerating && stop_dc_brake_mode; // R09
    st_next.updown_clear      = fn.act[ifd_pkg::B_UPDN_CLR] &&
                                freq_chan_updown; // R10

    // Clear dominates, then restore, then counting an accepted edge.
    // Restore reloads a count that was saved outside before power was lost.
    if (fn.act[ifd_pkg::B_CNT_CLR])
    begin
      st_next.cnt_value = ifd_pkg::CNT_RESET; // R06 R17
    end
    else if (cnt_restore)
    begin
      st_next.cnt_value = cnt_restore_value; // R05
    end
    else if (fn.rise[ifd_pkg::B_CNT_TRIG])
    begin
      st_next.cnt_value = st_reg.cnt_value + 32'h0000_0001; // R05 R17
    end

    // The pulse count clears while its terminal is active.
    // Only a terminal set up as a pulse input delivers these edges.
    if (fn.act[ifd_pkg::B_HS_CLR])
    begin
      st_next.hs_count = ifd_pkg::CNT_RESET; // R14
    end
    else if (fn.hs_rise)
    begin
      st_next.hs_count = st_reg.hs_count + 32'h0000_0001; // R15
    end

    // Command source priority: keypad, terminal, communication.
    // With no source terminal active the source reads as none.
    if (fn.act[ifd_pkg::B_CMD_KEYPAD])
    begin
      st_next.cmd_src = ifd_pkg::IFD_CMD_KEYPAD; // R11
    end
    else if (fn.act[ifd_pkg::B_CMD_TERMINAL])
    begin
      st_next.cmd_src = ifd_pkg::IFD_CMD_TERMINAL; // R11
    end
    else if (fn.act[ifd_pkg::B_CMD_COMM])
    begin
      st_next.cmd_src = ifd_pkg::IFD_CMD_COMM; // R11
    end
    else
    begin
      st_next.cmd_src = ifd_pkg::IFD_CMD_NONE;
    end

    // Run-state handling follows the chosen source.
    case (ifd_pkg::ifd_cmd_e'(st_next.cmd_src))
      ifd_pkg::IFD_CMD_TERMINAL:
      begin
        st_next.cmd_follow_start = two_wire_mode; // R12
        st_next.cmd_keep_run     = !two_wire_mode; // R12
      end
      ifd_pkg::IFD_CMD_KEYPAD, ifd_pkg::IFD_CMD_COMM:
      begin
        st_next.cmd_follow_start = 1'b0;
        st_next.cmd_keep_run     = 1'b1; // R12
      end
      default:
      begin
        st_next.cmd_follow_start = 1'b0;
        st_next.cmd_keep_run     = 1'b0;
      end
    endcase

    // Frequency source: main over auxiliary.
    // With neither terminal active the source reads as none.
    if (fn.act[ifd_pkg::B_FREQ_MAIN])
    begin
      st_next.freq_src = ifd_pkg::IFD_FREQ_MAIN; // R13
    end
    else if (fn.act[ifd_pkg::B_FREQ_AUX])
    begin
      st_next.freq_src = ifd_pkg::IFD_FREQ_AUX; // R13
    end
    else
    begin
      st_next.freq_src = ifd_pkg::IFD_FREQ_NONE;
    end
  end

  // State register.
  // Synchronous reset zeroes every output, the count included.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register.
  assign plc_zero_freq     = st_reg.plc_zero_freq;
  assign plc_start_inhibit = st_reg.plc_start_inhibit;
  assign plc_decel_stop    = st_reg.plc_decel_stop;
  assign plc_step_reset    = st_reg.plc_step_reset;
  assign pid_hold          = st_reg.pid_hold;
  assign pid_set2          = st_reg.pid_set2;
  assign cnt_value         = st_reg.cnt_value;
  assign length_clear      = st_reg.length_clear;
  assign accel_hold        = st_reg.accel_hold;
  assign dc_brake_now      = st_reg.dc_brake_now;
  assign updown_clear      = st_reg.updown_clear;
  assign cmd_src           = st_reg.cmd_src;
  assign cmd_keep_run      = st_reg.cmd_keep_run;
  assign cmd_follow_start  = st_reg.cmd_follow_start;
  assign freq_src          = st_reg.freq_src;
  assign hs_count          = st_reg.hs_count;

endmodule

// ### tb/ifd_input_terminal_decoder_monitor.sv
`timescale 1ns/100ps
module ifd_input_terminal_decoder_monitor (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        pid_switch_cond,
  input wire logic        plc_running,
  input wire logic        jog_active,
  input wire logic        decelerating,
  input wire logic        stop_dc_brake_mode,
  input wire logic        freq_chan_updown,
  input wire logic        two_wire_mode,
  input wire logic        cnt_restore,
  input wire logic        plc_start_inhibit,
  input wire logic        plc_step_reset,
  input wire logic        plc_decel_stop,
  input wire logic        pid_set2,
  input wire logic        accel_hold,
  input wire logic        dc_brake_now,
  input wire logic        updown_clear,
  input wire logic [1:0]  cmd_src,
  input wire logic        cmd_keep_run,
  input wire logic        cmd_follow_start,
  input wire logic [31:0] cnt_value,
  input wire logic [31:0] hs_count
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Gated outputs may only rise when their qualifying status was present; step-reset pairing, run-state handling and count steps are checked too.
  a_step_reset_pair: assert property (
    plc_step_reset == plc_start_inhibit)
    else $error("step reset and start inhibit differ");
  a_decel_running: assert property (plc_decel_stop |->
    plc_start_inhibit && $past(plc_running)) else $error("decel stop idle");
  a_pid_set_cond: assert property (pid_set2 |-> $past(pid_switch_cond))
    else $error("second PID set without condition");
  a_hold_not_jog: assert property (accel_hold |-> !$past(jog_active))
    else $error("speed hold during jog");
  a_brake_cond: assert property (dc_brake_now |->
    $past(decelerating && stop_dc_brake_mode))
    else $error("brake not allowed");
  a_updn_chan: assert property (updown_clear |->
    $past(freq_chan_updown)) else $error("offset clear on wrong channel");
  a_cmd_other_mode: assert property (cmd_src != 2'h2 |->
    !cmd_follow_start && cmd_keep_run == (cmd_src != 2'h0))
    else $error("run state handling wrong");
  a_cmd_two_wire: assert property (cmd_src == 2'h2 |->
    cmd_follow_start == $past(two_wire_mode) &&
    cmd_keep_run != cmd_follow_start)
    else $error("terminal mode run handling wrong");
  a_cnt_single_step: assert property ($changed(cnt_value) |->
    cnt_value == $past(cnt_value) + 32'h1 || cnt_value == 32'h0 ||
    $past(cnt_restore)) else $error("counter jumped");
  a_hs_single_step: assert property ($changed(hs_count) |->
    hs_count == $past(hs_count) + 32'h1 || hs_count == 32'h0)
    else $error("pulse count jumped");

  // Main scenarios reached.
  c_decel: cover property (plc_decel_stop);
  c_follow: cover property (cmd_follow_start);
  c_hs: cover property (hs_count == 32'h7);
endmodule

// ### tb/ifd_contact_model.sv
`timescale 1ns/100ps
module ifd_contact_model (
  input  wire logic       clk_sys,
  input  wire logic [4:0] want,
  input  wire logic       hs_go,
  input  wire logic [7:0] hs_n,
  output logic      [4:0] term_closed
);
  logic [4:0] cont_reg = 5'h00;
  logic [8:0] left_reg = 9'h000;

  // Contacts settle a cycle after the request; a burst pulses terminal 4.
  always_ff @(posedge clk_sys)
  begin
    cont_reg <= want;
    if (hs_go)
      left_reg <= {hs_n, 1'b0};
    else if (left_reg != 9'h000)
      left_reg <= left_reg - 9'h001;
  end

  // Each pulse is one cycle closed then one open, so every edge is clean.
  assign term_closed = {(left_reg != 9'h000) ? left_reg[0] : cont_reg[4],
                        cont_reg[3:0]};
endmodule

// ### tb/ifd_input_terminal_decoder_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end
module ifd_input_terminal_decoder_tb;
  logic            clk_sys = 1'b0;
  logic            nrst = 1'b0;
  logic [4:0]      want = 5'h00;
  logic [4:0]      term_positive = 5'h1f;
  logic            hs_pulse_mode = 1'b0;
  logic [4:0][5:0] term_func = '0;
  logic [6:0]      st = 7'h00;
  logic            cnt_restore = 1'b0;
  logic [31:0]     cnt_restore_value = 32'h0;
  logic            hs_go = 1'b0;
  logic [7:0]      hs_n = 8'h00;
  logic [4:0]      term_closed;
  logic            plc_zero_freq, plc_start_inhibit, plc_decel_stop;
  logic            plc_step_reset, pid_hold, pid_set2, length_clear;
  logic            accel_hold, dc_brake_now, updown_clear;
  logic            cmd_keep_run, cmd_follow_start;
  logic [1:0]      cmd_src, freq_src;
  logic [31:0]     cnt_value, hs_count;
  logic [15:0]     r = 16'h004a;
  logic [15:0]     e;
  int              num_errors = 0;
  int              samples_checked = 0;
  wire logic [15:0] got = {plc_zero_freq, plc_start_inhibit, plc_decel_stop,
    plc_step_reset, pid_hold, pid_set2, length_clear, accel_hold,
    dc_brake_now, updown_clear, cmd_src, cmd_keep_run, cmd_follow_start,
    freq_src};

  ifd_contact_model contacts (.clk_sys, .want, .hs_go, .hs_n, .term_closed);

  ifd_input_terminal_decoder dut (.clk_sys, .nrst, .term_closed,
    .term_positive, .hs_pulse_mode, .term_func, .pid_switch_cond(st[0]),
    .plc_running(st[1]), .jog_active(st[2]), .decelerating(st[3]),
    .stop_dc_brake_mode(st[4]), .freq_chan_updown(st[5]),
    .two_wire_mode(st[6]), .cnt_restore, .cnt_restore_value, .plc_zero_freq,
    .plc_start_inhibit, .plc_decel_stop, .plc_step_reset, .pid_hold,
    .pid_set2, .cnt_value, .length_clear, .accel_hold, .dc_brake_now,
    .updown_clear, .cmd_src, .cmd_keep_run, .cmd_follow_start, .freq_src,
    .hs_count);

  // Clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  // Shift register that supplies the repeatable random values.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Level outputs worked out from codes, contacts, sense and status.
  function automatic logic [15:0] expect_out(input logic [4:0][5:0] f,
    input logic [4:0] cl, input logic [4:0] pos, input logic hs,
    input logic [6:0] s);
    logic [15:0] a;
    logic [1:0]  c;
    logic [1:0]  q;
    a = 16'h0;
    for (int t = 0; t < 5; t++)
      if (!(t == 4 && hs) && f[t] >= 6'h12 && f[t] <= 6'h21 && cl[t] == pos[t])
        a[f[t] - 6'h12] = 1'b1;
    c = a[10] ? 2'h1 : a[11] ? 2'h2 : a[12] ? 2'h3 : 2'h0;
    q = a[13] ? 2'h1 : a[14] ? 2'h2 : 2'h0;
    return {a[0], a[1], a[1] & s[1], a[1], a[2], a[3] & s[0], a[6],
      a[7] & !s[2], a[8] & s[3] & s[4], a[9] & s[5], c,
      c == 2'h1 || c == 2'h3 || (c == 2'h2 && !s[6]), c == 2'h2 && s[6], q};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // n inactive-to-active strokes of the counting contact on terminal 0.
  task automatic pulse0(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      want[0] <= 1'b1;
      tick(2);
      want[0] <= 1'b0;
      tick(3);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    tick(5000);
    num_errors++;
    print_verdict();
  end

  // Main sequence: random decode, then counter and pulse-count corners.
  initial
  begin
    logic [4:0][5:0] fn;
    tick(16);
    nrst <= 1'b1;
    for (int k = 0; k < 64; k++)
    begin
      fn[0] = 6'h12 + 6'(k % 16);
      for (int t = 1; t < 5; t++)
      begin
        r = lfsr(r);
        fn[t] = 6'h10 + 6'(r % 20);
      end
      r = lfsr(r);
      term_func <= fn;
      want <= r[4:0];
      term_positive <= r[9:5];
      hs_pulse_mode <= r[10];
      r = lfsr(r);
      st <= r[6:0];
      tick(5);
      #1;
      e = expect_out(term_func, term_closed, term_positive, hs_pulse_mode, st);
      `CHK("plc and pid", e[15:10], got[15:10])
      `CHK("gated levels", e[9:6], got[9:6])
      `CHK("sources", e[5:0], got[5:0])
      @(posedge clk_sys);
    end
    hs_pulse_mode <= 1'b0;
    term_positive <= 5'h1f;
    want <= 5'h00;
    term_func <= {6'h16, 6'h00, 6'h21, 6'h17, 6'h16};
    tick(5);
    cnt_restore_value <= 32'h0000_0010;
    cnt_restore <= 1'b1;
    tick(1);
    cnt_restore <= 1'b0;
    tick(2);
    #1;
    `CHK("restore", 32'h0000_0010, cnt_value)
    pulse0(5);
    #1;
    `CHK("count", 32'h0000_0015, cnt_value)
    want[1] <= 1'b1;
    pulse0(3);
    #1;
    `CHK("held clear", 32'h0, cnt_value)
    want[1] <= 1'b0;
    tick(4);
    pulse0(1);
    hs_pulse_mode <= 1'b1;
    want[2] <= 1'b1;
    tick(5);
    want[2] <= 1'b0;
    tick(5);
    hs_n <= 8'h07;
    hs_go <= 1'b1;
    tick(1);
    hs_go <= 1'b0;
    tick(24);
    #1;
    `CHK("pulse count", 32'h7, hs_count)
    `CHK("counter kept", 32'h1, cnt_value)
    @(posedge clk_sys);
    want[2] <= 1'b1;
    tick(5);
    #1;
    `CHK("pulse clear", 32'h0, hs_count)
    // Mid-run reset with the counting contact closed throughout.
    @(posedge clk_sys);
    want[0] <= 1'b1;
    tick(3);
    nrst <= 1'b0;
    tick(3);
    #1;
    `CHK("reset count", 32'h0, cnt_value)
    @(posedge clk_sys);
    nrst <= 1'b1;
    tick(6);
    #1;
    `CHK("no false edge", 32'h0, cnt_value)
    print_verdict();
  end
endmodule

bind ifd_input_terminal_decoder ifd_input_terminal_decoder_monitor u_mon (
  .clk_sys, .nrst, .pid_switch_cond, .plc_running, .jog_active, .decelerating,
  .stop_dc_brake_mode, .freq_chan_updown, .two_wire_mode, .cnt_restore,
  .plc_start_inhibit, .plc_step_reset, .plc_decel_stop, .pid_set2,
  .accel_hold, .dc_brake_now, .updown_clear, .cmd_src, .cmd_keep_run,
  .cmd_follow_start, .cnt_value, .hs_count);
